// [rtl/ltb_pkg.sv]
// Package for the slow time base: register offsets, fields, reset values
package ltb_pkg;
    // Device registers, 16-bit, byte addressed (even = word)
    localparam logic [15:0] LTB_VALUE_OFS   = 16'hF3A0;
    localparam logic [15:0] LTB_CTRL_OFS    = 16'hF3A2;
    localparam logic [15:0] LTB_TRIM_OFS    = 16'hF3A6;
    localparam logic [15:0] LTB_INTSEL_OFS  = 16'hF3A8;
    localparam logic [15:0] LTB_CTRL_RST    = 16'h0203;
    localparam logic [15:0] LTB_TRIM_RST    = 16'h0000;
    localparam logic [15:0] LTB_INTSEL_RST  = 16'h7160;
    localparam logic [15:0] LTB_CTRL_WMASK  = 16'hCD03;
    localparam logic [15:0] LTB_TRIM_WMASK  = 16'h07FF;
    localparam logic [15:0] LTB_INTSEL_WMASK = 16'h7777;
    localparam logic [15:0] LTB_CTRL_FIXED  = 16'h0200;
    // Control fields
    localparam int LTB_RUN0_BIT   = 0;
    localparam int LTB_RUN1_BIT   = 1;
    localparam int LTB_CKSEL0_BIT = 8;
    localparam int LTB_TRIMEN0_BIT = 10;
    localparam int LTB_TRIMEN1_BIT = 11;
    localparam int LTB_TAPOUT_LSB = 14;
    // Trim: one count inserted/skipped per TRIM_SPAN slow clocks per LSB
    localparam int LTB_TRIM_BITS  = 11;
    localparam int LTB_TRIM_SPAN_BITS = 21; // 2^21 = 2097152
    // APB command register offsets of the host controller
    localparam logic [7:0] LTB_H_CMD_OFS    = 8'h00;
    localparam logic [7:0] LTB_H_WDATA_OFS  = 8'h04;
    localparam logic [7:0] LTB_H_RDATA_OFS  = 8'h08;
    localparam logic [7:0] LTB_H_STATUS_OFS = 8'h0C;
    localparam logic [7:0] LTB_H_FLAGS_OFS  = 8'h10;
endpackage

// [rtl/ltb_if.sv]
// Interface joining the time base device and its host controller
`timescale 1ns/1ps
`default_nettype none
interface ltb_if;
    logic [15:0] addr;   // Byte address
    logic        wr;     // One-cycle write strobe
    logic        rd;     // One-cycle read strobe
    logic [1:0]  be;     // Byte lanes: [0] even byte, [1] odd byte
    logic [15:0] wdata;
    logic [15:0] rdata;  // Valid the cycle after rd
    logic [3:0]  irq;    // One-cycle request pulses
    logic        slow_a; // Slow clock A level, from outside
    logic        slow_b; // Slow clock B level, from outside
    logic        tap_out;
    modport dev  (input addr, wr, rd, be, wdata, slow_a, slow_b,
                  output rdata, irq, tap_out);
    modport host (output addr, wr, rd, be, wdata,
                  input rdata, irq, tap_out);
endinterface
`default_nettype wire

// [rtl/ltb_divider.sv]
// One eight-tap slow divider with trim and clear
`timescale 1ns/1ps
`default_nettype none
module ltb_divider
    import ltb_pkg::*;
#(
    parameter int PRE_BITS = 7 // 32768 Hz / 2^7 = 256 Hz toggle rate
) (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       TICK,
    input  wire logic       RUN,
    input  wire logic       CLEAR,
    input  wire logic       TRIM_EN,
    input  wire logic [10:0] TRIM,
    output logic [7:0]      TAPS
);
    typedef struct packed {
        logic [PRE_BITS+7:0]         cnt;
        logic [LTB_TRIM_SPAN_BITS-1:0] acc;
    } ltb_div_s;
    ltb_div_s st_reg, st_next;
    logic [LTB_TRIM_SPAN_BITS:0] acc_sum;
    logic [LTB_TRIM_SPAN_BITS-1:0] mag;
    logic [10:0]                   trim_abs;

    // Phase accumulator chooses when a count is skipped or doubled
    always_comb begin
        st_next = st_reg;
        // Magnitude formed at 11 bits so the negation cannot spill
        // into the wider accumulator word
        trim_abs = TRIM[10] ? (~TRIM + 11'h001) : TRIM;
        mag = LTB_TRIM_SPAN_BITS'(trim_abs);
        acc_sum = {1'b0, st_reg.acc} + {1'b0, mag};
        if (CLEAR) begin
            st_next = '0; // All taps start low
        end else if (RUN && TICK) begin
            st_next.cnt = st_reg.cnt + 1'b1; // Count up
            if (TRIM_EN && TRIM != '0) begin
                st_next.acc = acc_sum[LTB_TRIM_SPAN_BITS-1:0];
                if (acc_sum[LTB_TRIM_SPAN_BITS]) begin
                    // Positive trim adds a count, negative holds one
                    st_next.cnt = TRIM[10] ? st_reg.cnt
                                           : st_reg.cnt + 2'd2;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) st_reg <= '0;
        else     st_reg <= st_next;
    end

    // Tap 0 is the fastest (128 Hz); each bit is low first half
    assign TAPS = st_reg.cnt[PRE_BITS+7:PRE_BITS];
endmodule
`default_nettype wire

// [rtl/ltb_device.sv]
// Slow time base device: two dividers, tap select, requests, trim
// Summary of operation
// - control bit 0 runs divider 0, resets run
// - software stops divider 0 before clock change
// - trim register holds 11 bits, resets zero
// - bits 14:12 pick divider1 tap, irq3
// - bits 10:8 pick divider1 tap, irq2
// - bits 6:4 pick divider0 tap, irq1
// - bits 2:0 pick divider0 tap, irq0
// - dividers count up from zero after reset
// - requests fire on selected tap falling edge
// - value register reads all sixteen tap levels
// - select write request flags one cycle later
// - software masks, waits, clears after select write
// - value writes clear dividers per byte lane
// - clearing may raise requests; software clears
// - value write request appears one cycle later
// - software times only between successive requests
// - trim shifts rate within about 488 ppm
// - correct trim gives exact 2 Hz count
// - trim is two's complement ratio times 2^21
// - control 15:14 route a request to pin
// - control 11:10 enable trim per divider
// - taps low first half, high second
`timescale 1ns/1ps
`default_nettype none
module ltb_device
    import ltb_pkg::*;
#(
    parameter int PRE_BITS = 7
) (
    input  wire logic CLK,
    input  wire logic RST,
    ltb_if.dev        BUS
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] trim;
        logic [15:0] intsel;
        logic [15:0] rdata;
        logic [1:0]  a_sync;
        logic [1:0]  b_sync;
        logic        a_prev;
        logic        b_prev;
        logic [3:0]  sel_prev;
        logic [3:0]  irq;
        logic        tap_out;
    } ltb_dev_s;
    ltb_dev_s st_reg, st_next;

    logic [7:0]  taps0;
    logic [7:0]  taps1;
    logic [3:0]  sel_now;
    logic        tick_a;
    logic        tick_b;
    logic        tick0;
    logic        clr0;
    logic        clr1;
    logic        wr_value;
    logic [15:0] wmask;

    // Slow clock falling edges, taken after two synchroniser stages
    assign tick_a = st_reg.a_prev & ~st_reg.a_sync[1];
    assign tick_b = st_reg.b_prev & ~st_reg.b_sync[1];
    assign tick0  = st_reg.ctrl[LTB_CKSEL0_BIT] ? tick_b : tick_a;
    assign wr_value = BUS.wr && BUS.addr == LTB_VALUE_OFS;
    assign clr0 = wr_value && BUS.be[0];
    assign clr1 = wr_value && BUS.be[1];
    assign wmask = {{8{BUS.be[1]}}, {8{BUS.be[0]}}};

    ltb_divider #(.PRE_BITS(PRE_BITS)) u_div0 (
        .CLK     (CLK),
        .RST     (RST),
        .TICK    (tick0),
        .RUN     (st_reg.ctrl[LTB_RUN0_BIT]),
        .CLEAR   (clr0),
        .TRIM_EN (st_reg.ctrl[LTB_TRIMEN0_BIT]),
        .TRIM    (st_reg.trim[10:0]),
        .TAPS    (taps0)
    );
    ltb_divider #(.PRE_BITS(PRE_BITS)) u_div1 (
        .CLK     (CLK),
        .RST     (RST),
        .TICK    (tick_b),
        .RUN     (st_reg.ctrl[LTB_RUN1_BIT]),
        .CLEAR   (clr1),
        .TRIM_EN (st_reg.ctrl[LTB_TRIMEN1_BIT]),
        .TRIM    (st_reg.trim[10:0]),
        .TAPS    (taps1)
    );

    // Selected tap levels, live from the current select fields
    assign sel_now = {taps1[st_reg.intsel[14:12]],
                      taps1[st_reg.intsel[10:8]],
                      taps0[st_reg.intsel[6:4]],
                      taps0[st_reg.intsel[2:0]]};

    // Register writes, read mux and request edge detection
    always_comb begin
        st_next = st_reg;
        st_next.a_sync = {st_reg.a_sync[0], BUS.slow_a};
        st_next.b_sync = {st_reg.b_sync[0], BUS.slow_b};
        st_next.a_prev = st_reg.a_sync[1];
        st_next.b_prev = st_reg.b_sync[1];
        if (BUS.wr) begin
            case (BUS.addr)
                LTB_CTRL_OFS: begin
                    st_next.ctrl = (st_reg.ctrl & ~(wmask & LTB_CTRL_WMASK))
                        | (BUS.wdata & wmask & LTB_CTRL_WMASK)
                        | LTB_CTRL_FIXED;
                end
                LTB_TRIM_OFS: begin
                    st_next.trim = (st_reg.trim & ~(wmask & LTB_TRIM_WMASK))
                        | (BUS.wdata & wmask & LTB_TRIM_WMASK);
                end
                LTB_INTSEL_OFS: begin
                    st_next.intsel = (st_reg.intsel
                        & ~(wmask & LTB_INTSEL_WMASK))
                        | (BUS.wdata & wmask & LTB_INTSEL_WMASK);
                end
                default: begin
                end
            endcase
        end
        if (BUS.rd) begin
            case (BUS.addr)
                LTB_VALUE_OFS:  st_next.rdata = {taps1, taps0};
                LTB_CTRL_OFS:   st_next.rdata = st_reg.ctrl;
                LTB_TRIM_OFS:   st_next.rdata = st_reg.trim;
                LTB_INTSEL_OFS: st_next.rdata = st_reg.intsel;
                default:        st_next.rdata = '0;
            endcase
        end
        // A write changing taps or selects shows next cycle as a
        // falling edge; flags are not blocked
        st_next.sel_prev = sel_now;
        st_next.irq = st_reg.sel_prev & ~sel_now;
        // Pin shows the chosen request line
        st_next.tap_out = st_reg.irq[st_reg.ctrl[15:LTB_TAPOUT_LSB]];
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_reg <= '0;
            st_reg.ctrl <= LTB_CTRL_RST;
            st_reg.trim <= LTB_TRIM_RST;
            st_reg.intsel <= LTB_INTSEL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign BUS.rdata   = st_reg.rdata;
    assign BUS.irq     = st_reg.irq;
    assign BUS.tap_out = st_reg.tap_out;
endmodule
`default_nettype wire

// [rtl/ltb_host.sv]
// Host controller: APB slave that issues device accesses and latches flags
`timescale 1ns/1ps
`default_nettype none
module ltb_host
    import ltb_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    ltb_if.host              DEV
);
    typedef struct packed {
        logic [15:0] addr;
        logic [1:0]  be;
        logic        wr;
        logic        rd;
        logic        rd_wait;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [3:0]  flags;
        logic [31:0] prdata;
    } ltb_host_s;
    ltb_host_s st_reg, st_next;
    logic acc;

    assign acc = PSEL && PENABLE;

    // Command word: [15:0] address, [17:16] lanes, [18] write, [19] read
    always_comb begin
        st_next = st_reg;
        st_next.wr = 1'b0;
        st_next.rd = 1'b0;
        st_next.rd_wait = st_reg.rd;
        if (st_reg.rd_wait) st_next.rdata = DEV.rdata;
        // Flags set wins over a clear in the same cycle
        if (acc && PWRITE && PADDR == LTB_H_FLAGS_OFS)
            st_next.flags = st_reg.flags & ~PWDATA[3:0];
        st_next.flags = st_next.flags | DEV.irq;
        if (acc && PWRITE) begin
            case (PADDR)
                LTB_H_CMD_OFS: begin
                    st_next.addr = PWDATA[15:0];
                    st_next.be   = PWDATA[17:16];
                    st_next.wr   = PWDATA[18];
                    st_next.rd   = PWDATA[19] & ~PWDATA[18];
                end
                LTB_H_WDATA_OFS: st_next.wdata = PWDATA[15:0];
                default: begin
                end
            endcase
        end
        if (acc && !PWRITE) begin
            case (PADDR)
                LTB_H_RDATA_OFS:  st_next.prdata = {16'h0000, st_reg.rdata};
                LTB_H_STATUS_OFS: st_next.prdata = {30'h0, DEV.tap_out,
                    st_reg.rd | st_reg.rd_wait};
                LTB_H_FLAGS_OFS:  st_next.prdata = {28'h0, st_reg.flags};
                default:          st_next.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) st_reg <= '0;
        else     st_reg <= st_next;
    end

    assign PREADY    = 1'b1;
    assign PSLVERR   = 1'b0;
    assign PRDATA    = st_next.prdata;
    assign DEV.addr  = st_reg.addr;
    assign DEV.be    = st_reg.be;
    assign DEV.wr    = st_reg.wr;
    assign DEV.rd    = st_reg.rd;
    assign DEV.wdata = st_reg.wdata;
endmodule
`default_nettype wire

// [tb/ltb_props.sv]
// Concurrent checks on the link between host and time base device
`timescale 1ns/1ps
`default_nettype none
module ltb_props (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [15:0] addr,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [1:0]  be,
    input wire logic [15:0] rdata,
    input wire logic [3:0]  irq,
    input wire logic        tap_out
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // Clear of divider 0, then a value read; 40 cycles allow 2 ticks
    sequence s_clr0;
        wr && addr == 16'hF3A0 && be[0];
    endsequence
    sequence s_rdv;
        rd && addr == 16'hF3A0;
    endsequence
    property p_clr0;
        s_clr0 ##[2:40] s_rdv |=> rdata[7:1] == 7'h00;
    endproperty
    property p_rst_quiet;
        $fell(RST) |-> irq == 4'h0 && !tap_out && rdata == 16'h0000;
    endproperty
    property p_irq_pulse;
        irq != 4'h0 |=> (irq & $past(irq)) == 4'h0;
    endproperty
    property p_tap_out;
        tap_out |-> $past(irq) != 4'h0;
    endproperty
    property p_rdata_hold;
        !$past(rd) |-> $stable(rdata);
    endproperty
    property p_unmapped;
        rd && addr == 16'hF3A4 |=> rdata == 16'h0000;
    endproperty
    property p_trim_rsv;
        rd && addr == 16'hF3A6 |=> rdata[15:11] == 5'h00;
    endproperty
    property p_sel_rsv;
        rd && addr == 16'hF3A8 |=> (rdata & 16'h8888) == 16'h0000;
    endproperty
    a_clr0: assert property (p_clr0)
        else $error("value low byte not cleared");
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("link not quiet after reset");
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("request longer than one cycle");
    a_tap_out: assert property (p_tap_out)
        else $error("pin pulse without request");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without read");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_trim_rsv: assert property (p_trim_rsv)
        else $error("trim reserved bits set");
    a_sel_rsv: assert property (p_sel_rsv)
        else $error("select reserved bits set");
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Bench: host and device joined, driven over APB, self-checking
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ltb_pkg::*;
;
    localparam int LTB_PRE   = 1;     // Short prefix keeps gaps small
    localparam int SLOW_HALF = 10;    // Slow clock half period, cycles
    localparam int LIMIT     = 60000; // Hang guard, cycles
    typedef struct packed {
        logic [15:0] addr;
        logic [1:0]  be;    // Zero means read only
        logic [15:0] wdata;
        logic [15:0] exp;
    } ltb_row_s;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        slow_q = 1'b0;
    logic [7:0]  slow_cnt = 8'h00;
    logic [15:0] q;
    logic [31:0] gap;
    logic [31:0] gap_exp;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    ltb_row_s    rows [13] = '{
        '{16'hF3A2, 2'h0, 16'h0000, 16'h0203},
        '{16'hF3A6, 2'h0, 16'h0000, 16'h0000},
        '{16'hF3A8, 2'h0, 16'h0000, 16'h7160},
        '{16'hF3A4, 2'h3, 16'hFFFF, 16'h0000},
        '{16'hF3A6, 2'h3, 16'hFFFF, 16'h07FF},
        '{16'hF3A6, 2'h1, 16'h0000, 16'h0700},
        '{16'hF3A6, 2'h3, 16'h0400, 16'h0400},
        '{16'hF3A8, 2'h3, 16'hFFFF, 16'h7777},
        '{16'hF3A8, 2'h2, 16'h0000, 16'h0077},
        '{16'hF3A8, 2'h3, 16'h7160, 16'h7160},
        '{16'hF3A2, 2'h3, 16'h0000, 16'h0200},
        '{16'hF3A0, 2'h3, 16'h0000, 16'h0000},
        '{16'hF3A2, 2'h3, 16'hFFFF, 16'hCF03}};
    ltb_if bus ();
    assign bus.slow_a = slow_q;
    assign bus.slow_b = ~slow_q;
    ltb_host ltb_host_i (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(), .DEV(bus));
    ltb_device #(.PRE_BITS(LTB_PRE)) ltb_device_i (
        .CLK(clk), .RST(rst), .BUS(bus));
    ltb_props ltb_props_i (
        .CLK(clk), .RST(rst), .addr(bus.addr), .wr(bus.wr), .rd(bus.rd),
        .be(bus.be), .rdata(bus.rdata), .irq(bus.irq), .tap_out(bus.tap_out));
    // 100 MHz system clock
    always #5 clk = ~clk;
    // Slow clocks from the system clock, plus the hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 8'h00 : slow_cnt + 8'h01;
        if (slow_cnt == SLOW_HALF - 1) begin
            slow_q <= ~slow_q;
        end
        if (cyc == LIMIT) begin
            fail_count++;
            final_report();
        end
    end
    task automatic final_report();
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Device access through the host: data, command, wait, result
    task automatic dev(input logic w, input logic [15:0] a,
                       input logic [1:0] be, input logic [15:0] d,
                       output logic [15:0] v);
        logic [31:0] r;
        apb(1'b1, LTB_H_WDATA_OFS, {16'h0000, d}, r);
        apb(1'b1, LTB_H_CMD_OFS, {12'h000, ~w, w, be, a}, r);
        r = 32'h1;
        while (r[0] !== 1'b0) apb(1'b0, LTB_H_STATUS_OFS, 32'h0, r);
        apb(1'b0, LTB_H_RDATA_OFS, 32'h0, r);
        v = r[15:0];
    endtask
    // Gap between two pulses of one request; first one may be stale
    task automatic measure(input logic [1:0] idx, output logic [31:0] g);
        g = 32'h1;
        @(posedge clk);
        while (bus.irq[idx] !== 1'b1) @(posedge clk);
        @(posedge clk);
        check("tap_out", {31'h0, bus.tap_out}, 32'h1);
        while (bus.irq[idx] !== 1'b1) begin
            @(posedge clk);
            g++;
        end
    endtask
    // Table first, then stop, byte clears, tap codes and a second reset
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            if (rows[i].be != 2'h0) dev(1'b1, rows[i].addr, rows[i].be,
                                        rows[i].wdata, q);
            dev(1'b0, rows[i].addr, 2'h3, 16'h0000, q);
            check("reg", {16'h0, q}, {16'h0, rows[i].exp});
        end
        dev(1'b1, 16'hF3A2, 2'h3, 16'h0102, q); // Stop divider 0
        dev(1'b1, 16'hF3A2, 2'h3, 16'h0002, q);
        dev(1'b1, 16'hF3A0, 2'h3, 16'h0000, q);
        repeat (400) @(posedge clk);
        dev(1'b0, 16'hF3A0, 2'h3, 16'h0000, q);
        check("stopped", {24'h0, q[7:0]}, 32'h0);
        check("running", {31'h0, q[15:8] != 8'h00}, 32'h1);
        dev(1'b1, 16'hF3A2, 2'h3, 16'h0003, q);
        repeat (400) @(posedge clk);
        dev(1'b1, 16'hF3A0, 2'h1, 16'h0000, q);
        dev(1'b0, 16'hF3A0, 2'h3, 16'h0000, q);
        check("low_clr", {25'h0, q[7:1]}, 32'h0);
        check("high_kept", {31'h0, q[15:8] != 8'h00}, 32'h1);
        dev(1'b1, 16'hF3A0, 2'h2, 16'h0000, q);
        dev(1'b0, 16'hF3A0, 2'h3, 16'h0000, q);
        check("high_clr", {25'h0, q[15:9]}, 32'h0);
        for (int k = 0; k < 8; k++) begin
            dev(1'b1, 16'hF3A2, 2'h3, {k[1:0], 14'h0003}, q);
            dev(1'b1, 16'hF3A8, 2'h3, {4{1'b0, k[2:0]}}, q);
            measure(k[1:0], gap);
            gap_exp = (2 * SLOW_HALF) << (LTB_PRE + 1 + k);
            check("gap", gap, gap_exp);
        end
        apb(1'b0, LTB_H_FLAGS_OFS, 32'h0, gap);
        check("flags_set", gap, 32'h0000000F);
        apb(1'b1, LTB_H_FLAGS_OFS, 32'h0000000F, gap);
        apb(1'b0, LTB_H_FLAGS_OFS, 32'h0, gap);
        check("flags_clr", gap, 32'h00000000);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        dev(1'b0, 16'hF3A8, 2'h3, 16'h0000, q);
        check("sel_rst", {16'h0, q}, 32'h7160);
        dev(1'b0, 16'hF3A2, 2'h3, 16'h0000, q);
        check("ctrl_rst", {16'h0, q}, 32'h0203);
        final_report();
    end
endmodule
`default_nettype wire
